// ==== logic/asp_defs.svh ====
// Timing and field constants for the asynchronous serial port.
// Assumes inclusion by bare name from files under logic/.
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH
`define ASP_OVERSAMPLE 16
`define ASP_HALF_BIT 8
`define ASP_CLK_HZ 40000000
`define ASP_BAUD_DEFAULT 9600
`define ASP_DATA_MAX 8
`define ASP_ADDR_DEFAULT 8'h01
`endif

// ==== logic/asp_pkg.sv ====
// Types shared by the asynchronous serial port files.
// Assumes asp_defs.svh is on the include path.
`default_nettype none
package asp_pkg;
  typedef enum logic [2:0]
  {
    ASP_PAR_NONE = 3'h0,
    ASP_PAR_ODD = 3'h1,
    ASP_PAR_EVEN = 3'h2,
    ASP_PAR_MARK = 3'h3,
    ASP_PAR_SPACE = 3'h4
  } asp_parity_e;
  typedef enum logic [1:0]
  {
    ASP_LEN5 = 2'h0,
    ASP_LEN6 = 2'h1,
    ASP_LEN7 = 2'h2,
    ASP_LEN8 = 2'h3
  } asp_len_e;
  typedef enum logic [1:0]
  {
    ASP_HS_NONE = 2'h0,
    ASP_HS_PTT = 2'h1,
    ASP_HS_RESTRAINT = 2'h2
  } asp_hs_e;
endpackage
`default_nettype wire

// ==== logic/asp_tick_gen.sv ====
// Oversampling tick generator: one pulse every DIV clocks.
// Assumes a synchronous, active-high internal reset.
`default_nettype none
module asp_tick_gen
#(
  parameter int DIV = 260
)
(
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  initial
  begin
    if (DIV < 1 || DIV > 65536)
      $error("Divider must lie between one and the counter range.");
  end
  logic [15:0] cnt_ff;
  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_ff <= 16'h0;
    else if (cnt_ff == 16'(DIV - 1))
      cnt_ff <= 16'h0;
    else
      cnt_ff <= cnt_ff + 16'h1;
  end
  assign tick = (cnt_ff == 16'(DIV - 1));
endmodule
`default_nettype wire

// ==== logic/asp_parity.sv ====
// Parity bit calculation over a masked character.
// Assumes data bits above the character length are already zero.
`default_nettype none
module asp_parity
(
  input wire logic [7:0] data,
  input wire asp_pkg::asp_parity_e mode,
  output logic bit_out
);
  import asp_pkg::*;
  always_comb
  begin
    unique case (mode)
      ASP_PAR_ODD: bit_out = ~(^data);
      ASP_PAR_EVEN: bit_out = ^data;
      ASP_PAR_MARK: bit_out = 1'b1;
      default: bit_out = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ==== logic/asp_top.sv ====
// Asynchronous serial port: transmitter, receiver, handshakes, address filter.
// Assumes CLK at 40 MHz; line pins are asynchronous and get synchronised here.
`include "asp_defs.svh"
`default_nettype none
module asp_top
#(
  parameter int CLK_HZ = `ASP_CLK_HZ,
  parameter int BAUD = `ASP_BAUD_DEFAULT
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  output logic TX_BUSY,
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  input wire logic RX_READY,
  output logic RX_PARITY_ERR,
  output logic RX_FRAME_ERR,
  input wire asp_pkg::asp_len_e CFG_LEN,
  input wire asp_pkg::asp_parity_e CFG_PARITY,
  input wire logic CFG_TWO_STOP,
  input wire asp_pkg::asp_hs_e CFG_HANDSHAKE,
  input wire logic CFG_CTS_GATE,
  input wire logic CFG_USE_DTR,
  input wire logic CFG_MULTIDROP,
  input wire logic CFG_ADDR_FILTER,
  input wire logic [7:0] CFG_OWN_ADDR,
  input wire logic SERIAL_IN,
  output logic SERIAL_OUT,
  output logic SERIAL_OE_N,
  input wire logic CTS_IN,
  output logic RTS_OUT,
  output logic DTR_OUT
);
  import asp_pkg::*;
  localparam int DIV = CLK_HZ / (BAUD * `ASP_OVERSAMPLE);
  initial
  begin
    if (DIV < 1)
      $error("Clock too slow for the chosen baud rate.");
  end

  typedef enum logic [4:0]
  {
    ASP_TX_IDLE = 5'b00001,
    ASP_TX_START = 5'b00010,
    ASP_TX_DATA = 5'b00100,
    ASP_TX_PAR = 5'b01000,
    ASP_TX_STOP = 5'b10000
  } asp_txst_e;
  typedef enum logic [4:0]
  {
    ASP_RX_IDLE = 5'b00001,
    ASP_RX_START = 5'b00010,
    ASP_RX_DATA = 5'b00100,
    ASP_RX_PAR = 5'b01000,
    ASP_RX_STOP = 5'b10000
  } asp_rxst_e;

  logic rst_a_ff, rst_b_ff, rst;
  logic rx_s1_ff, rx_s2_ff, cts_s1_ff, cts_s2_ff;
  logic tick;
  logic [2:0] nbits;
  logic [7:0] mask;
  logic tx_par, rx_par;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_a_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end
    else
    begin
      rst_a_ff <= 1'b1;
      rst_b_ff <= rst_a_ff;
    end
  end
  assign rst = ~rst_b_ff;

  // Line inputs pass two flip-flops; the line idles at mark.
  always_ff @(posedge CLK)
  begin
    if (rst)
    begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      cts_s1_ff <= 1'b0;
      cts_s2_ff <= 1'b0;
    end
    else
    begin
      rx_s1_ff <= SERIAL_IN;
      rx_s2_ff <= rx_s1_ff;
      cts_s1_ff <= CTS_IN;
      cts_s2_ff <= cts_s1_ff;
    end
  end

  asp_tick_gen #(.DIV(DIV)) u_tick (.clk(CLK), .rst(rst), .tick(tick));

  assign nbits = 3'(4 + CFG_LEN);
  assign mask = 8'hff >> (3'h7 - nbits);

  // Transmitter.
  asp_txst_e tx_st_ff;
  logic [3:0] tx_tick_ff;
  logic [2:0] tx_bit_ff;
  logic [7:0] tx_sh_ff;
  logic tx_line_ff, tx_stop2_ff, tx_p_ff, tx_hold_ff;
  logic tx_may_start;

  asp_parity u_tx_par (.data(TX_DATA & mask), .mode(CFG_PARITY), .bit_out(tx_par));

  // Clear must be asserted before any new character when gating applies.
  // Push-to-talk waits until its own request is on the line before clear counts.
  assign tx_may_start = (~(CFG_CTS_GATE | CFG_HANDSHAKE != ASP_HS_NONE) | cts_s2_ff) &
                        ((CFG_HANDSHAKE != ASP_HS_PTT) | RTS_OUT);
  assign TX_READY = (tx_st_ff == ASP_TX_IDLE) & tx_may_start;
  assign TX_BUSY = (tx_st_ff != ASP_TX_IDLE);

  always_ff @(posedge CLK)
  begin
    if (rst)
    begin
      tx_st_ff <= ASP_TX_IDLE;
      tx_tick_ff <= 4'h0;
      tx_bit_ff <= 3'h0;
      tx_sh_ff <= 8'h0;
      tx_line_ff <= 1'b1;
      tx_stop2_ff <= 1'b0;
      tx_p_ff <= 1'b0;
    end
    else
    begin
      unique case (tx_st_ff)
        ASP_TX_IDLE:
        begin
          tx_line_ff <= 1'b1;
          if (TX_VALID && TX_READY)
          begin
            tx_sh_ff <= TX_DATA & mask;
            tx_p_ff <= tx_par;
            tx_line_ff <= 1'b0;
            tx_tick_ff <= 4'h0;
            tx_st_ff <= ASP_TX_START;
          end
        end
        ASP_TX_START:
        begin
          if (tick)
          begin
            tx_tick_ff <= tx_tick_ff + 4'h1;
            if (tx_tick_ff == 4'hf)
            begin
              tx_line_ff <= tx_sh_ff[0];
              tx_bit_ff <= 3'h0;
              tx_st_ff <= ASP_TX_DATA;
            end
          end
        end
        ASP_TX_DATA:
        begin
          if (tick)
          begin
            tx_tick_ff <= tx_tick_ff + 4'h1;
            if (tx_tick_ff == 4'hf)
            begin
              if (tx_bit_ff == nbits)
              begin
                if (CFG_PARITY != ASP_PAR_NONE)
                begin
                  tx_line_ff <= tx_p_ff;
                  tx_st_ff <= ASP_TX_PAR;
                end
                else
                begin
                  tx_line_ff <= 1'b1;
                  tx_stop2_ff <= CFG_TWO_STOP;
                  tx_st_ff <= ASP_TX_STOP;
                end
              end
              else
              begin
                tx_line_ff <= tx_sh_ff[tx_bit_ff + 3'h1];
                tx_bit_ff <= tx_bit_ff + 3'h1;
              end
            end
          end
        end
        ASP_TX_PAR:
        begin
          if (tick)
          begin
            tx_tick_ff <= tx_tick_ff + 4'h1;
            if (tx_tick_ff == 4'hf)
            begin
              tx_line_ff <= 1'b1;
              tx_stop2_ff <= CFG_TWO_STOP;
              tx_st_ff <= ASP_TX_STOP;
            end
          end
        end
        ASP_TX_STOP:
        begin
          if (tick)
          begin
            tx_tick_ff <= tx_tick_ff + 4'h1;
            if (tx_tick_ff == 4'hf)
            begin
              if (tx_stop2_ff)
                tx_stop2_ff <= 1'b0;
              else
                tx_st_ff <= ASP_TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Push-to-talk request stays up while data waits or a character is on the line.
  always_ff @(posedge CLK)
  begin
    if (rst)
      tx_hold_ff <= 1'b0;
    else
      tx_hold_ff <= TX_VALID | (tx_st_ff != ASP_TX_IDLE);
  end

  // Outside reset, in multidrop the driver floats whenever the transmitter is idle and TX_VALID is low.
  always_ff @(posedge CLK)
  begin
    if (rst)
    begin
      SERIAL_OUT <= 1'b1;
      SERIAL_OE_N <= 1'b0;
    end
    else
    begin
      SERIAL_OUT <= tx_line_ff;
      SERIAL_OE_N <= CFG_MULTIDROP & (tx_st_ff == ASP_TX_IDLE) & ~TX_VALID;
    end
  end

  // Receiver.
  asp_rxst_e rx_st_ff;
  logic [3:0] rx_tick_ff;
  logic [2:0] rx_bit_ff;
  logic [7:0] rx_sh_ff;
  logic rx_pbit_ff, rx_addr_phase_ff, rx_drop_ff;

  asp_parity u_rx_par (.data(rx_sh_ff & mask), .mode(CFG_PARITY), .bit_out(rx_par));

  always_ff @(posedge CLK)
  begin
    if (rst)
    begin
      rx_st_ff <= ASP_RX_IDLE;
      rx_tick_ff <= 4'h0;
      rx_bit_ff <= 3'h0;
      rx_sh_ff <= 8'h0;
      rx_pbit_ff <= 1'b0;
      RX_DATA <= 8'h0;
      RX_VALID <= 1'b0;
      RX_PARITY_ERR <= 1'b0;
      RX_FRAME_ERR <= 1'b0;
      rx_addr_phase_ff <= 1'b1;
      rx_drop_ff <= 1'b0;
    end
    else
    begin
      if (RX_VALID && RX_READY)
        RX_VALID <= 1'b0;
      if (!CFG_ADDR_FILTER)
      begin
        rx_addr_phase_ff <= 1'b1;
        rx_drop_ff <= 1'b0;
      end
      unique case (rx_st_ff)
        ASP_RX_IDLE:
        begin
          if (!rx_s2_ff)
          begin
            rx_tick_ff <= 4'h0;
            rx_st_ff <= ASP_RX_START;
          end
        end
        ASP_RX_START:
        begin
          if (tick)
          begin
            rx_tick_ff <= rx_tick_ff + 4'h1;
            if (rx_tick_ff == 4'(`ASP_HALF_BIT - 1))
            begin
              rx_tick_ff <= 4'h0;
              if (rx_s2_ff)
                rx_st_ff <= ASP_RX_IDLE;
              else
              begin
                rx_bit_ff <= 3'h0;
                rx_sh_ff <= 8'h0;
                rx_st_ff <= ASP_RX_DATA;
              end
            end
          end
        end
        ASP_RX_DATA:
        begin
          if (tick)
          begin
            rx_tick_ff <= rx_tick_ff + 4'h1;
            if (rx_tick_ff == 4'hf)
            begin
              rx_sh_ff[rx_bit_ff] <= rx_s2_ff;
              rx_bit_ff <= rx_bit_ff + 3'h1;
              if (rx_bit_ff == nbits)
                rx_st_ff <= (CFG_PARITY != ASP_PAR_NONE) ? ASP_RX_PAR : ASP_RX_STOP;
            end
          end
        end
        ASP_RX_PAR:
        begin
          if (tick)
          begin
            rx_tick_ff <= rx_tick_ff + 4'h1;
            if (rx_tick_ff == 4'hf)
            begin
              rx_pbit_ff <= rx_s2_ff;
              rx_st_ff <= ASP_RX_STOP;
            end
          end
        end
        ASP_RX_STOP:
        begin
          if (tick)
          begin
            rx_tick_ff <= rx_tick_ff + 4'h1;
            if (rx_tick_ff == 4'hf)
            begin
              // Search resumes here, mid stop bit; a second stop is idle mark.
              rx_st_ff <= ASP_RX_IDLE;
              if (CFG_ADDR_FILTER && rx_addr_phase_ff)
              begin
                rx_drop_ff <= ((rx_sh_ff & mask) != (CFG_OWN_ADDR & mask));
                rx_addr_phase_ff <= 1'b0;
              end
              if (!(CFG_ADDR_FILTER && (rx_addr_phase_ff ?
                  ((rx_sh_ff & mask) != (CFG_OWN_ADDR & mask)) : rx_drop_ff)))
              begin
                RX_DATA <= rx_sh_ff & mask;
                RX_VALID <= 1'b1;
                RX_PARITY_ERR <= (CFG_PARITY != ASP_PAR_NONE) &
                                 (rx_pbit_ff != rx_par);
                RX_FRAME_ERR <= ~rx_s2_ff;
              end
              if (!rx_s2_ff)
                rx_addr_phase_ff <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Restraint: RTS_OUT, or DTR_OUT when CFG_USE_DTR is set, drops while a received character waits unread.
  always_ff @(posedge CLK)
  begin
    if (rst)
    begin
      RTS_OUT <= 1'b0;
      DTR_OUT <= 1'b1;
    end
    else
    begin
      unique case (CFG_HANDSHAKE)
        ASP_HS_PTT:
        begin
          RTS_OUT <= tx_hold_ff;
          DTR_OUT <= 1'b1;
        end
        ASP_HS_RESTRAINT:
        begin
          RTS_OUT <= CFG_USE_DTR ? 1'b1 : ~RX_VALID;
          DTR_OUT <= CFG_USE_DTR ? ~RX_VALID : 1'b1;
        end
        default:
        begin
          RTS_OUT <= 1'b1;
          DTR_OUT <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== testbench/asp_top_sva.sv ====
// Checker for line timing, handshakes and receive data of the serial port.
// Assumes it is bound into asp_top.
`default_nettype none
module asp_top_sva
  import asp_pkg::*;
#(
  parameter int CLK_HZ = 40000000,
  parameter int BAUD = 9600
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire logic TX_BUSY,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  input wire asp_pkg::asp_len_e CFG_LEN,
  input wire asp_pkg::asp_hs_e CFG_HANDSHAKE,
  input wire logic CFG_CTS_GATE,
  input wire logic CFG_USE_DTR,
  input wire logic CFG_MULTIDROP,
  input wire logic SERIAL_OUT,
  input wire logic SERIAL_OE_N,
  input wire logic CTS_IN,
  input wire logic RTS_OUT,
  input wire logic DTR_OUT
);
  localparam int DIV = CLK_HZ / (BAUD * 16);
  localparam int BITC = 16 * DIV;
  logic last_ff;
  int run_ff;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // Length of the current run of one line level.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      last_ff <= 1'b1;
      run_ff <= 0;
    end
    else
    begin
      last_ff <= SERIAL_OUT;
      run_ff <= (SERIAL_OUT != last_ff) ? 1 : run_ff + 1;
    end
  end
  sequence s_take;
    TX_VALID && TX_READY;
  endsequence
  sequence s_held;
    (CFG_CTS_GATE || CFG_HANDSHAKE != ASP_HS_NONE) && !CTS_IN;
  endsequence
  sequence s_start;
    (!SERIAL_OUT && !SERIAL_OE_N) [*8];
  endsequence
  start_space_a: assert property (s_take |-> ##2 s_start)
    else $error("no start bit");
  bit_time_a: assert property (SERIAL_OUT && !last_ff |->
    run_ff % BITC == 0 || BITC - run_ff % BITC <= DIV)
    else $error("bit length");
  busy_ready_a: assert property (TX_BUSY |-> !TX_READY)
    else $error("ready while busy");
  cts_gate_a: assert property (s_held [*4] |-> !TX_READY)
    else $error("ready while not clear");
  ptt_rts_a: assert property (CFG_HANDSHAKE == ASP_HS_PTT && TX_BUSY |-> RTS_OUT)
    else $error("request dropped");
  restrain_a: assert property ((CFG_HANDSHAKE == ASP_HS_RESTRAINT && RX_VALID) [*2]
    |-> !(CFG_USE_DTR ? DTR_OUT : RTS_OUT))
    else $error("no restraint");
  oe_idle_a: assert property ((CFG_MULTIDROP && !TX_BUSY && !TX_VALID) [*3]
    |-> SERIAL_OE_N)
    else $error("driver not floating");
  rx_len_a: assert property (RX_VALID |-> (RX_DATA >> (5 + CFG_LEN)) == 8'h00)
    else $error("bits above length");
endmodule
bind asp_top asp_top_sva #(.CLK_HZ(CLK_HZ), .BAUD(BAUD)) asp_top_sva_i (.CLK(CLK),
  .RST_N(RST_N), .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_BUSY(TX_BUSY),
  .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .CFG_LEN(CFG_LEN), .CFG_HANDSHAKE(CFG_HANDSHAKE),
  .CFG_CTS_GATE(CFG_CTS_GATE), .CFG_USE_DTR(CFG_USE_DTR), .CFG_MULTIDROP(CFG_MULTIDROP),
  .SERIAL_OUT(SERIAL_OUT), .SERIAL_OE_N(SERIAL_OE_N), .CTS_IN(CTS_IN), .RTS_OUT(RTS_OUT),
  .DTR_OUT(DTR_OUT));
`default_nettype wire

// ==== testbench/asp_peer.sv ====
// Far-end serial peer: sends whole frames and drives the clear line.
// Assumes the bench hands it frame bits after the start bit.
`default_nettype none
module asp_peer
#(
  parameter int BITC = 16
)
(
  input wire logic clk,
  input wire logic rts,
  input wire logic rmode,
  input wire logic ptt,
  input wire logic hold,
  output var logic line,
  output var logic cts
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    line = 1'b1;
    cts = 1'b1;
  end
  always @(posedge clk)
    cts <= !hold && (!ptt || rts);
  task automatic send(input logic [11:0] v, input int n);
    int i;
    i = 0;
    while (rmode && !rts && i++ < 5000)
      @(posedge clk);
    for (i = -1; i < n; i++)
    begin
      @(posedge clk);
      line <= (i < 0) ? 1'b0 : v[i];
      repeat (BITC - 1) @(posedge clk);
    end
    @(posedge clk);
    line <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== testbench/asp_top_tb_top.sv ====
// Self-checking bench for framing, parity, handshakes and the receive path.
// Assumes the design under logic/ and the peer model.
`default_nettype none
module asp_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import asp_pkg::*;
  localparam int BITC = 16;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic TX_VALID = 1'b0;
  logic RX_READY = 1'b0;
  logic CFG_TWO_STOP = 1'b0;
  logic CFG_CTS_GATE = 1'b0;
  logic CFG_USE_DTR = 1'b0;
  logic CFG_MULTIDROP = 1'b0;
  logic CFG_ADDR_FILTER = 1'b0;
  logic [7:0] CFG_OWN_ADDR = 8'h00;
  logic hold = 1'b0;
  logic [7:0] TX_DATA = 8'h00;
  asp_len_e CFG_LEN = ASP_LEN8;
  asp_parity_e CFG_PARITY = ASP_PAR_NONE;
  asp_hs_e CFG_HANDSHAKE = ASP_HS_NONE;
  wire logic TX_READY, TX_BUSY, RX_VALID, RX_PARITY_ERR, RX_FRAME_ERR, SERIAL_OUT;
  wire logic SERIAL_OE_N, SERIAL_IN, CTS_IN, RTS_OUT, DTR_OUT;
  wire logic [7:0] RX_DATA;
  int bad_count = 0;
  int n_checks = 0;
  int k;
  always #12.5 CLK = ~CLK;
  asp_top #(.BAUD(2500000)) asp_top_i (.CLK(CLK), .RST_N(RST_N), .TX_DATA(TX_DATA),
    .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_BUSY(TX_BUSY), .RX_DATA(RX_DATA),
    .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_PARITY_ERR(RX_PARITY_ERR),
    .RX_FRAME_ERR(RX_FRAME_ERR), .CFG_LEN(CFG_LEN), .CFG_PARITY(CFG_PARITY),
    .CFG_TWO_STOP(CFG_TWO_STOP), .CFG_HANDSHAKE(CFG_HANDSHAKE), .CFG_CTS_GATE(CFG_CTS_GATE),
    .CFG_USE_DTR(CFG_USE_DTR), .CFG_MULTIDROP(CFG_MULTIDROP),
    .CFG_ADDR_FILTER(CFG_ADDR_FILTER), .CFG_OWN_ADDR(CFG_OWN_ADDR),
    .SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT),
    .SERIAL_OE_N(SERIAL_OE_N), .CTS_IN(CTS_IN), .RTS_OUT(RTS_OUT), .DTR_OUT(DTR_OUT));
  asp_peer #(.BITC(BITC)) asp_peer_i (.clk(CLK), .rts(CFG_USE_DTR ? DTR_OUT : RTS_OUT),
    .rmode(CFG_HANDSHAKE == ASP_HS_RESTRAINT), .ptt(CFG_HANDSHAKE == ASP_HS_PTT),
    .hold(hold), .line(SERIAL_IN), .cts(CTS_IN));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  // Frame bits after the start bit, in line order, for the current settings.
  function automatic logic [11:0] fr(input logic [7:0] d, output int n);
    logic [11:0] v;
    logic [7:0] m;
    v = 12'hfff;
    m = d & (8'hff >> (3 - CFG_LEN));
    for (n = 0; n < 5 + CFG_LEN; n++)
      v[n] = m[n];
    if (CFG_PARITY != ASP_PAR_NONE)
    begin
      v[n] = (CFG_PARITY == ASP_PAR_ODD) ? ~^m : (CFG_PARITY == ASP_PAR_EVEN) ? ^m
        : (CFG_PARITY == ASP_PAR_MARK);
      n++;
    end
    n = n + 1 + CFG_TWO_STOP;
    return v;
  endfunction
  task automatic tx(input logic [7:0] d);
    logic [11:0] v;
    int n;
    int i;
    v = fr(d, n);
    @(posedge CLK);
    TX_DATA <= d;
    TX_VALID <= 1'b1;
    i = 0;
    do @(negedge CLK); while (TX_READY !== 1'b1 && ++i < 500);
    @(posedge CLK);
    TX_VALID <= 1'b0;
    i = 0;
    while (SERIAL_OUT !== 1'b0 && i++ < 50)
      @(negedge CLK);
    repeat (8) @(negedge CLK);
    chk(SERIAL_OUT === 1'b0, "start");
    for (i = 0; i < n; i++)
    begin
      repeat (BITC) @(negedge CLK);
      chk(SERIAL_OUT === v[i], "tx bit");
    end
    i = 0;
    while (TX_BUSY !== 1'b0 && i++ < 50)
      @(negedge CLK);
  endtask
  task automatic rx(input logic [7:0] d, input logic pe, input logic fe);
    logic [11:0] v;
    int n;
    int i;
    v = fr(d, n);
    pe = pe && CFG_PARITY != ASP_PAR_NONE;
    v[5 + CFG_LEN] ^= pe;
    if (fe)
      v[n - 1 - CFG_TWO_STOP] = 1'b0;
    asp_peer_i.send(v, n);
    i = 0;
    while (RX_VALID !== 1'b1 && i++ < 40)
      @(negedge CLK);
    repeat (2) @(negedge CLK);
    chk(RX_DATA === (d & (8'hff >> (3 - CFG_LEN))), "rx data");
    chk({RX_PARITY_ERR, RX_FRAME_ERR} === {pe, fe}, "rx error");
    if (CFG_HANDSHAKE == ASP_HS_RESTRAINT)
      chk((CFG_USE_DTR ? DTR_OUT : RTS_OUT) === 1'b0, "restraint");
    @(posedge CLK);
    RX_READY <= 1'b1;
    @(posedge CLK);
    RX_READY <= 1'b0;
  endtask
  initial
  begin
    #(25ns * 60000);
    bad_count++;
    $display("[FAIL] %0t watchdog", $time);
    report_and_stop();
  end
  initial
  begin
    void'($urandom(25522));
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    for (k = 0; k < 40; k++)
    begin
      @(posedge CLK);
      CFG_LEN <= asp_len_e'(k % 4);
      CFG_TWO_STOP <= 1'((k / 4) % 2);
      CFG_PARITY <= asp_parity_e'(k / 8);
      CFG_HANDSHAKE <= asp_hs_e'($urandom_range(2));
      CFG_USE_DTR <= 1'($urandom_range(1));
      CFG_MULTIDROP <= 1'($urandom_range(1));
      @(posedge CLK);
      tx(8'($urandom));
      rx(8'($urandom), 1'(k % 3 == 1), 1'(k % 5 == 2));
    end
    // Address filter: own address opens, a break reopens, a foreign address is dropped.
    @(posedge CLK);
    CFG_HANDSHAKE <= ASP_HS_NONE;
    CFG_PARITY <= ASP_PAR_NONE;
    CFG_LEN <= ASP_LEN8;
    CFG_TWO_STOP <= 1'b0;
    CFG_ADDR_FILTER <= 1'b1;
    CFG_OWN_ADDR <= 8'h3c;
    @(posedge CLK);
    rx(8'h3c, 1'b0, 1'b0);
    rx(8'ha5, 1'b0, 1'b0);
    rx(8'h00, 1'b0, 1'b1);
    asp_peer_i.send({3'h7, 1'b1, 8'h11}, 9);
    repeat (20) @(negedge CLK);
    chk(RX_VALID === 1'b0, "foreign address kept");
    CFG_ADDR_FILTER <= 1'b0;
    @(posedge CLK);
    CFG_HANDSHAKE <= ASP_HS_NONE;
    CFG_CTS_GATE <= 1'b1;
    hold <= 1'b1;
    repeat (4) @(posedge CLK);
    TX_DATA <= 8'h5a;
    TX_VALID <= 1'b1;
    k = 0;
    repeat (40) @(negedge CLK) k += (SERIAL_OUT !== 1'b1);
    chk(k == 0, "sent while held");
    @(posedge CLK);
    hold <= 1'b0;
    tx(8'h5a);
    report_and_stop();
  end
endmodule
`default_nettype wire
